/* File: tx_status_command.sv */
// Transmit queue, status register and command register of one channel
// Notes on behaviour
// RQ1: Any write address in the 32-byte window feeds the next queue entry.
// RQ2: Queue takes byte or word writes; characters leave least significant bit first.
// RQ3: Interrupt mode host writes at most 32 bytes per pool-ready event.
// RQ4: DMA mode host loads the byte count before starting.
// RQ5: Odd counts with word access send exactly the count, no pad.
// RQ6: Transmit-frame in DMA mode requests full blocks then a remainder.
// RQ7: Immediate-character pending rises on the load write, holds until start.
// RQ8: Software leaves the immediate register alone while pending is set.
// RQ9: Pending clears within 2.5 periods when sending can start at once.
// RQ10: Immediate character behaves the same with or without flow control.
// RQ11: Command-executing reads 1 while a command runs; no new command then.
// RQ12: Command-executing lasts at most 2.5 periods, but holds during power-down.
// RQ13: Status bit 1 reads 1 when the active-low clear-to-send pin is low.
// RQ14: Command bits 7..0: rx-complete, rx-reset, rx-read, timer, frame, 0, 0, tx-reset.
// RQ15: Interrupt mode transmit-frame sends the bytes already loaded.
// RQ16: Transmitter reset empties queue, idles line, aborts, raises pool-ready.
// RQ17: DMA mode output starts at 32 bytes held or count reached.
// RQ18: Shared address reads status and writes command independently.
// RQ19: Status bits 7..1 as listed; bit 0 reads zero.
// RQ20: Overflow sets on too many bytes; clears on reset or hand-over.
`timescale 1ns/10ps
module tx_status_command
  import tx_status_pkg::*;
#(
  parameter int DEPTH      = tx_status_pkg::QUEUE_BYTES,
  parameter int CMD_CYC    = tx_status_pkg::CMD_CYCLES,
  parameter int BAUD_DIV   = 16
)
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Register port
  input  wire logic [6:0] addr,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  input  wire logic       word_mode,
  input  wire logic [15:0] wr_data,
  output logic [7:0]      rd_data,
  // DMA handshake
  output logic            dma_req,
  // Line and surrounding state
  input  wire logic       cts_n,
  input  wire logic       flow_xoff,
  input  wire logic       rx_not_empty,
  input  wire logic       power_down,
  output logic            txd,
  output logic            tx_pool_ready_irq,
  output logic [7:0]      rx_cmd_pulses
);
  import tx_status_pkg::*;

  // Width of the bit-time divider
  localparam int BAUD_W = $clog2(BAUD_DIV);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [7:0]  queue_reg [DEPTH];
  logic [5:0]  fill_reg;
  logic [4:0]  head_reg;
  logic        dma_sel_reg;
  logic [11:0] count_reg;
  logic [11:0] sent_reg;
  logic        overflow_reg;
  logic        busy_reg;
  logic [7:0]  imm_reg;
  logic        imm_pend_reg;
  logic [3:0]  cmd_cnt_reg;
  logic        cts_reg;
  tx_state_t   state_reg;
  logic [7:0]  rd_data_reg;
  logic        dma_req_reg;
  logic        irq_reg;
  logic [7:0]  rx_cmd_reg;
  logic        txd_reg;
  logic [3:0]  shift_cnt_reg;
  logic [9:0]  shift_reg;
  logic        shifting_reg;
  logic [BAUD_W-1:0] baud_reg;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  wire in_window  = (addr & TX_QUEUE_MASK) == TX_QUEUE_BASE;        // RQ1
  wire q_write    = wr_en && in_window;
  wire cmd_write  = wr_en && addr == STATUS_CMD_ADDR;                  // RQ18
  wire stat_read  = rd_en && addr == STATUS_CMD_ADDR;                  // RQ18
  wire tic_write  = wr_en && addr == TIC_ADDR;
  wire cnt_lo_wr  = wr_en && addr == TX_COUNT_LOW;
  wire cnt_hi_wr  = wr_en && addr == TX_COUNT_HIGH;
  wire cmd_busy   = (cmd_cnt_reg != 4'd0) || power_down;               // RQ12
  wire do_xreset  = cmd_write && wr_data[CMD_XRESET];
  wire do_xmit    = cmd_write && wr_data[CMD_XMIT];
  wire baud_tick  = (baud_reg == '0);

  // Word writes carry two bytes; an odd tail in DMA mode keeps one
  wire [11:0] left     = count_reg - sent_reg;
  wire        two_ok   = word_mode && !(dma_sel_reg && left == 12'd1);  // RQ5
  wire [1:0]  n_bytes  = !q_write ? 2'd0 : (two_ok ? 2'd2 : 2'd1);     // RQ2
  wire [6:0]  room     = 7'(DEPTH) - {1'b0, fill_reg};
  wire        too_many = q_write && ({5'd0, n_bytes} > room);          // RQ20
  wire [5:0]  fill_add = too_many ? 6'd0 : {4'd0, n_bytes};

  // DMA block boundary: full queue or count reached
  wire dma_block_done = dma_sel_reg && state_reg == TX_DMA &&
                        (fill_reg == 6'(DEPTH) || sent_reg == count_reg); // RQ17

  // Status byte
  wire [7:0] status = {overflow_reg, !busy_reg, rx_not_empty, flow_xoff,
                       imm_pend_reg, cmd_busy, cts_reg, 1'b0};         // RQ19

  // Skid buffer between queue and shifter
  tx_byte_t buf_in;
  tx_byte_t buf_out;
  logic     buf_in_ready;
  logic     buf_out_valid;
  wire      queue_pop = busy_reg && fill_reg != 6'd0 && buf_in_ready && !flow_xoff;
  wire      take_imm  = imm_pend_reg && !shifting_reg && buf_out_valid == 1'b0; // RQ10
  wire      take_byte = !shifting_reg && !take_imm && buf_out_valid && baud_tick;
  assign buf_in = '{data: queue_reg[head_reg], last: fill_reg == 6'd1};

  tx_skid_buffer #(.WIDTH($bits(tx_byte_t))) skid
  (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .flush     (do_xreset),
    .in_data   (buf_in),
    .in_valid  (queue_pop),
    .in_ready  (buf_in_ready),
    .out_data  (buf_out),
    .out_valid (buf_out_valid),
    .out_ready (take_byte)
  );

  // ----------------------------------------
  // Queue fill and head
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst || do_xreset)                                          // RQ16
    begin
      fill_reg <= 6'd0;
      head_reg <= 5'd0;
    end
    else
    begin
      if (q_write && !too_many)
      begin
        queue_reg[5'(head_reg + fill_reg)] <= wr_data[7:0];
        if (n_bytes == 2'd2)
          queue_reg[5'(head_reg + fill_reg + 6'd1)] <= wr_data[15:8];
      end
      fill_reg <= fill_reg + fill_add - {5'd0, queue_pop};
      if (queue_pop)
        head_reg <= head_reg + 5'd1;
    end
  end

  // ----------------------------------------
  // Counts and mode
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      dma_sel_reg <= 1'b0;
      count_reg   <= 12'h000;
      sent_reg    <= 12'h000;
    end
    else
    begin
      if (cnt_lo_wr)
        count_reg[7:0] <= wr_data[7:0];                                // RQ4
      if (cnt_hi_wr)
      begin
        count_reg[11:8] <= wr_data[CNT_HI_BITS-1:0];
        dma_sel_reg     <= wr_data[CNT_DMA_BIT];
      end
      if (do_xmit || do_xreset)
        sent_reg <= 12'h000;
      else if (state_reg == TX_DMA && q_write && !too_many)
        sent_reg <= sent_reg + {10'd0, n_bytes};                       // RQ5
    end
  end

  // ----------------------------------------
  // Frame state machine
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst || do_xreset)
    begin
      state_reg   <= TX_IDLE;
      busy_reg    <= 1'b0;
      dma_req_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        TX_IDLE:
          if (do_xmit && dma_sel_reg)
          begin
            state_reg   <= TX_DMA;                                     // RQ6
            dma_req_reg <= 1'b1;
          end
          else if (do_xmit)
          begin
            state_reg <= TX_SEND;                                      // RQ15
            busy_reg  <= 1'b1;
          end
        TX_DMA:
          if (dma_block_done)
          begin
            dma_req_reg <= 1'b0;                                       // RQ6
            busy_reg    <= 1'b1;                                       // RQ17
            state_reg   <= TX_SEND;
          end
        TX_SEND:
          if (fill_reg == 6'd0 && !buf_out_valid && !shifting_reg)
          begin
            busy_reg <= 1'b0;
            if (dma_sel_reg && sent_reg != count_reg)
            begin
              state_reg   <= TX_DMA;                                   // RQ6
              dma_req_reg <= 1'b1;
            end
            else
              state_reg <= TX_IDLE;
          end
        default:
          state_reg <= TX_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Overflow, pool-ready event, immediate char
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      overflow_reg <= 1'b0;
      irq_reg      <= 1'b0;
      imm_pend_reg <= 1'b0;
      imm_reg      <= 8'h00;
    end
    else
    begin
      if (too_many)
        overflow_reg <= 1'b1;                                          // RQ20
      else if (do_xreset || do_xmit)
        overflow_reg <= 1'b0;                                          // RQ20
      irq_reg <= do_xreset ||                                          // RQ16
                 (state_reg == TX_SEND && fill_reg == 6'd1 && queue_pop && !dma_sel_reg);
      if (tic_write)
      begin
        imm_reg      <= wr_data[7:0];
        imm_pend_reg <= 1'b1;                                          // RQ7
      end
      else if (take_imm)
        imm_pend_reg <= 1'b0;                                          // RQ9
    end
  end

  // ----------------------------------------
  // Command timing and status capture
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cmd_cnt_reg <= 4'd0;
      cts_reg     <= 1'b0;
      rd_data_reg <= 8'h00;
      rx_cmd_reg  <= COMMAND_RESET;
    end
    else
    begin
      if (cmd_write)
        cmd_cnt_reg <= 4'(CMD_CYC);                                    // RQ11
      else if (cmd_cnt_reg != 4'd0)
        cmd_cnt_reg <= cmd_cnt_reg - 4'd1;                             // RQ12
      cts_reg     <= !cts_n;                                           // RQ13
      rd_data_reg <= stat_read ? status : 8'h00;
      rx_cmd_reg  <= cmd_write ? (wr_data[7:0] & 8'hF0) : 8'h00;       // RQ14
    end
  end

  // ----------------------------------------
  // Serial shifter, LSB first
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst || do_xreset)
    begin
      txd_reg       <= 1'b1;                                           // RQ16
      shifting_reg  <= 1'b0;
      shift_reg     <= 10'h3FF;
      shift_cnt_reg <= 4'd0;
      baud_reg      <= '0;
    end
    else
    begin
      baud_reg <= baud_tick ? BAUD_W'(BAUD_DIV - 1) : baud_reg - 1'b1;
      if (take_imm || take_byte)
      begin
        shift_reg     <= {1'b1, take_imm ? imm_reg : buf_out.data, 1'b0};
        shifting_reg  <= 1'b1;
        shift_cnt_reg <= 4'd10;
      end
      else if (shifting_reg && baud_tick)
      begin
        txd_reg       <= shift_reg[0];                                 // RQ2
        shift_reg     <= {1'b1, shift_reg[9:1]};
        shift_cnt_reg <= shift_cnt_reg - 4'd1;
        shifting_reg  <= shift_cnt_reg != 4'd1;
      end
    end
  end

  // Outputs from flip-flops
  assign rd_data           = rd_data_reg;
  assign dma_req           = dma_req_reg;
  assign txd               = txd_reg;
  assign tx_pool_ready_irq = irq_reg;
  assign rx_cmd_pulses     = rx_cmd_reg;

endmodule

/* File: tx_status_pkg.sv */
// Package for the transmit queue, status and command block
package tx_status_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [6:0] TX_QUEUE_BASE   = 7'h00;  // 32-byte window 00..1F
  localparam logic [6:0] TX_QUEUE_MASK   = 7'h60;  // Bits that select the window
  localparam logic [6:0] STATUS_CMD_ADDR = 7'h20;  // Status on read, command on write
  localparam logic [6:0] TIC_ADDR        = 7'h35;
  localparam logic [6:0] TX_COUNT_LOW    = 7'h2A;
  localparam logic [6:0] TX_COUNT_HIGH   = 7'h2B;

  // ----------------------------------------
  // Reset values and field positions
  // ----------------------------------------
  localparam logic [7:0] STATUS_RESET  = 8'h40;
  localparam logic [7:0] COMMAND_RESET = 8'h00;
  localparam int ST_OVERFLOW  = 7;
  localparam int ST_WRITE_EN  = 6;
  localparam int ST_RX_NE     = 5;
  localparam int ST_FLOW      = 4;
  localparam int ST_IMM_PEND  = 3;
  localparam int ST_CMD_EXEC  = 2;
  localparam int ST_CTS       = 1;
  localparam int CMD_RMC      = 7;
  localparam int CMD_RECEIVER_RESET_CMD     = 6;
  localparam int CMD_RX_QUEUE_READ_CMD     = 5;
  localparam int CMD_STI      = 4;
  localparam int CMD_XMIT     = 3;
  localparam int CMD_XRESET   = 0;
  localparam int CNT_DMA_BIT  = 7;  // DMA select in high count
  localparam int CNT_HI_BITS  = 4;  // Count bits held in high count

  // ----------------------------------------
  // Sizes and timing
  // ----------------------------------------
  localparam int QUEUE_BYTES   = 32;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int CMD_TIME_PS   = 12500;  // 2.5 clock periods
  localparam int CMD_CYCLES    = (CMD_TIME_PS / CLK_PERIOD_PS < 1) ? 1
                                 : CMD_TIME_PS / CLK_PERIOD_PS;

  // Byte travelling through the skid buffer
  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } tx_byte_t;

  // Block state
  typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_DMA} tx_state_t;

endpackage

/* File: tx_skid_buffer.sv */
// Two-entry valid/ready buffer for transmit bytes
`timescale 1ns/10ps
module tx_skid_buffer
#(
  parameter int WIDTH = 9
)
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             flush,
  // Fill side
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  // Drain side
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  logic [WIDTH-1:0] slot_reg [2];
  logic [1:0]       count_reg;
  logic             rd_reg;
  logic             wr_reg;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  // Flags and head word
  assign in_ready  = (count_reg != 2'd2);
  assign out_valid = (count_reg != 2'd0);
  assign out_data  = slot_reg[rd_reg];

  // Storage and pointers
  always_ff @(posedge clk)
  begin
    if (sys_rst || flush)
    begin
      count_reg <= 2'd0;
      rd_reg    <= 1'b0;
      wr_reg    <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        slot_reg[wr_reg] <= in_data;
        wr_reg           <= ~wr_reg;
      end
      if (pop)
        rd_reg <= ~rd_reg;
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule

/* File: tx_status_checker.sv */
// Concurrent checks on the ports of the transmit queue and status block
`timescale 1ns/10ps
module tx_status_checker
  import tx_status_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // Register port
  input wire logic [6:0]  addr,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic        word_mode,
  input wire logic [15:0] wr_data,
  input wire logic [7:0]  rd_data,
  // Line and status
  input wire logic        dma_req,
  input wire logic        cts_n,
  input wire logic        flow_xoff,
  input wire logic        rx_not_empty,
  input wire logic        power_down,
  input wire logic        txd,
  input wire logic        tx_pool_ready_irq,
  input wire logic [7:0]  rx_cmd_pulses
);
  // Decoded accesses to the shared address
  wire logic       st_rd  = rd_en && addr == STATUS_CMD_ADDR;
  wire logic       cmd_w  = wr_en && addr == STATUS_CMD_ADDR;
  wire logic [3:0] cmd_hi = wr_data[7:4];
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // Transmitter reset and the idle line that must follow it
  sequence transmitter_reset_cmd_wr;
    cmd_w && wr_data[CMD_XRESET];
  endsequence
  sequence line_idle;
    ##[1:4] txd [*4];
  endsequence
  // Status fields and read data
  a_read_idle_zero: assert property (!st_rd |=> rd_data == 8'h00)
    else $error("read data not zero outside a status read");
  a_bit0_zero: assert property (st_rd |=> !rd_data[0])
    else $error("status bit 0 not zero");
  a_cts_level: assert property (st_rd |=> rd_data[ST_CTS] == !$past(cts_n, 2))
    else $error("clear-to-send status wrong");
  a_rx_ne_bit: assert property (st_rd |=> rd_data[ST_RX_NE] == $past(rx_not_empty))
    else $error("receive not empty status wrong");
  a_flow_bit: assert property (st_rd |=> rd_data[ST_FLOW] == $past(flow_xoff))
    else $error("flow control status wrong");
  a_power_cec: assert property (st_rd && power_down |=> rd_data[ST_CMD_EXEC])
    else $error("command executing low in power-down");
  // Command pulses and transmitter reset
  a_cmd_echo: assert property (cmd_w |=> rx_cmd_pulses == {$past(cmd_hi), 4'h0})
    else $error("command pulses do not match written command");
  a_echo_single: assert property (rx_cmd_pulses != 8'h00 |=> rx_cmd_pulses == 8'h00)
    else $error("command pulse longer than one cycle");
  a_irq_single: assert property ($rose(tx_pool_ready_irq) |=> !tx_pool_ready_irq)
    else $error("pool ready pulse longer than one cycle");
  a_transmitter_reset_cmd_irq: assert property (transmitter_reset_cmd_wr |-> ##[1:4] tx_pool_ready_irq)
    else $error("no pool ready after transmitter reset");
  a_transmitter_reset_cmd_idle: assert property (transmitter_reset_cmd_wr |-> line_idle)
    else $error("line not idle after transmitter reset");
endmodule

bind tx_status_command tx_status_checker tx_status_checker_inst (
  .clk, .sys_rst, .addr, .wr_en, .rd_en, .word_mode, .wr_data, .rd_data, .dma_req,
  .cts_n, .flow_xoff, .rx_not_empty, .power_down, .txd, .tx_pool_ready_irq, .rx_cmd_pulses
);

/* File: host_model.sv */
// Host bus and DMA controller model for the register port
`timescale 1ns/10ps
module host_model
(
  // Clock
  input  wire logic       clk,
  // Register port
  output logic [6:0]      addr,
  output logic            wr_en,
  output logic            rd_en,
  output logic            word_mode,
  output logic [15:0]     wr_data,
  input  wire logic [7:0] rd_data,
  // DMA request
  input  wire logic       dma_req
);
  int         left = 0;      // Bytes the DMA engine still owes
  logic [7:0] nxt  = 8'h40;  // Next DMA byte value
  // Idle bus at time zero
  initial
  begin
    addr = 7'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    word_mode = 1'b0;
    wr_data = 16'h0000;
  end
  // One write, held for a full clock
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge clk);
    #1;
    addr = a;
    wr_data = d;
    wr_en = 1'b1;
    @(posedge clk);
    #1;
    wr_en = 1'b0;
    wr_data = ~d;  // Released data never repeats
  endtask
  // One read; data stands the cycle after the strobe
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    addr = a;
    rd_en = 1'b1;
    @(posedge clk);
    #1;
    rd_en = 1'b0;
    d = rd_data;
  endtask
  // Arms the DMA engine with a byte total
  task automatic dma_load(input int n);
    nxt = 8'h40;
    left = n;
  endtask
  // Level-driven DMA, a gap after each write so the request can drop
  always
  begin
    @(posedge clk);
    #1;
    if (dma_req === 1'b1 && left > 0)
    begin
      wr(7'(left % 32), {nxt + 8'h01, nxt});
      nxt = nxt + (word_mode ? 8'h02 : 8'h01);
      left = left - (word_mode ? 2 : 1);
    end
  end
endmodule

/* File: tb.sv */
// Self-checking testbench for the transmit queue, status and command block
`timescale 1ns/10ps
module tb;
  import tx_status_pkg::*;
  localparam int BD = 8;  // Short bit time keeps the run brief
  logic        clk          = 1'b0;
  logic        sys_rst      = 1'b1;
  logic        cts_n        = 1'b1;
  logic        flow_xoff    = 1'b0;
  logic        rx_not_empty = 1'b0;
  logic        power_down   = 1'b0;
  logic [6:0]  addr;
  logic        wr_en;
  logic        rd_en;
  logic        word_mode;
  logic [15:0] wr_data;
  logic [7:0]  rd_data;
  logic        dma_req;
  logic        txd;
  logic        tx_pool_ready_irq;
  logic [7:0]  rx_cmd_pulses;
  logic [7:0]  ch;
  logic [7:0]  rx_q[$];
  int          n_mismatch  = 0;
  int          check_count = 0;
  int          n_irq       = 0;
  int          n_req       = 0;
  // Design, host model and clock
  tx_status_command #(.BAUD_DIV(BD)) tx_status_command_inst (
    .clk, .sys_rst, .addr, .wr_en, .rd_en, .word_mode, .wr_data, .rd_data, .dma_req,
    .cts_n, .flow_xoff, .rx_not_empty, .power_down, .txd, .tx_pool_ready_irq, .rx_cmd_pulses);
  host_model host_model_inst (
    .clk, .addr, .wr_en, .rd_en, .word_mode, .wr_data, .rd_data, .dma_req);
  always #2.5 clk = ~clk;
  // Event counters
  always @(posedge tx_pool_ready_irq) n_irq++;
  always @(posedge dma_req) n_req++;
  // Line receiver, sampled mid-bit
  always @(negedge txd)
  begin
    repeat (BD / 2) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BD) @(posedge clk);
      ch[i] = txd;
    end
    repeat (BD) @(posedge clk);
    check("stop bit", {7'h00, txd}, 8'h01);
    rx_q.push_back(ch);
  end
  // Compare and report
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Command write after the executing window has closed
  task automatic cmd(input logic [7:0] d);
    repeat (4) @(posedge clk);
    host_model_inst.wr(STATUS_CMD_ADDR, {8'h00, d});
  endtask
  task automatic wait_bytes(input int n);
    for (int i = 0; i < 5000 && rx_q.size() < n; i++) @(posedge clk);
  endtask
  // Status fields, power-down, unmapped read, receiver command bits 7..4
  task automatic t_status();
    logic [7:0] v;
    host_model_inst.rd(STATUS_CMD_ADDR, v);
    check("status reset", v, STATUS_RESET);
    cts_n = 1'b0;
    rx_not_empty = 1'b1;
    flow_xoff = 1'b1;
    power_down = 1'b1;
    host_model_inst.rd(STATUS_CMD_ADDR, v);
    check("status inputs", v, 8'h76);
    cts_n = 1'b1;
    rx_not_empty = 1'b0;
    flow_xoff = 1'b0;
    power_down = 1'b0;
    for (int b = 4; b < 8; b++) cmd(8'h01 << b);
    cmd(8'h00);
    host_model_inst.rd(STATUS_CMD_ADDR, v);
    check("command executing", v, STATUS_RESET | (8'h01 << ST_CMD_EXEC));
    host_model_inst.rd(STATUS_CMD_ADDR, v);
    check("status after cmds", v, STATUS_RESET);
    host_model_inst.rd(7'h29, v);
    check("unmapped read", v, 8'h00);
  endtask
  // Interrupt-mode frame with byte and word writes across the window
  task automatic t_frame();
    logic [7:0] exp[4] = '{8'hA5, 8'h3C, 8'hC3, 8'h5A};
    int irq0;
    rx_q.delete();
    host_model_inst.wr(7'h00, 16'h00A5);
    host_model_inst.wr(7'h1F, 16'h003C);
    host_model_inst.word_mode = 1'b1;
    host_model_inst.wr(7'h0A, 16'h5AC3);
    host_model_inst.word_mode = 1'b0;
    irq0 = n_irq;
    cmd(8'h08);
    wait_bytes(4);
    for (int i = 0; i < 4; i++) check("frame byte", rx_q[i], exp[i]);
    check("frame irq", {7'h00, n_irq != irq0}, 8'h01);
  endtask
  // Immediate character, busy then idle with flow control on
  task automatic t_tic();
    logic [7:0] v;
    logic       hit = 1'b0;
    rx_q.delete();
    host_model_inst.wr(7'h00, 16'h0011);
    host_model_inst.wr(7'h01, 16'h0022);
    cmd(8'h08);
    repeat (4 * BD) @(posedge clk);
    host_model_inst.wr(TIC_ADDR, 16'h0055);
    host_model_inst.rd(STATUS_CMD_ADDR, v);
    check("pending busy", {7'h00, v[ST_IMM_PEND]}, 8'h01);
    wait_bytes(3);
    foreach (rx_q[i]) hit |= rx_q[i] === 8'h55;
    check("immediate sent", {7'h00, hit}, 8'h01);
    repeat (2 * BD) @(posedge clk);
    flow_xoff = 1'b1;
    host_model_inst.wr(TIC_ADDR, 16'h0066);
    host_model_inst.rd(STATUS_CMD_ADDR, v);
    check("pending idle", {7'h00, v[ST_IMM_PEND]}, 8'h00);
    wait_bytes(4);
    check("immediate xoff", rx_q[3], 8'h66);
    flow_xoff = 1'b0;
  endtask
  // Overflow, then transmitter reset empties the queue
  task automatic t_overflow();
    logic [7:0] v;
    int irq0;
    int q0;
    for (int i = 0; i < 33; i++) host_model_inst.wr(7'(i % 32), 16'(i));
    host_model_inst.rd(STATUS_CMD_ADDR, v);
    check("overflow set", v & 8'hC0, 8'hC0);
    irq0 = n_irq;
    q0 = rx_q.size();
    cmd(8'h01);
    cmd(8'h08);
    repeat (300) @(posedge clk);
    host_model_inst.rd(STATUS_CMD_ADDR, v);
    check("overflow clear", {7'h00, v[ST_OVERFLOW]}, 8'h00);
    check("reset irq", {7'h00, n_irq != irq0}, 8'h01);
    check("queue flushed", 8'(rx_q.size() - q0), 8'h00);
  endtask
  // DMA with an odd count above one block, word accesses
  task automatic t_dma();
    int r0;
    host_model_inst.wr(TX_COUNT_HIGH, 16'h0080);
    host_model_inst.wr(TX_COUNT_LOW, 16'h0023);
    host_model_inst.word_mode = 1'b1;
    host_model_inst.dma_load(35);
    rx_q.delete();
    r0 = n_req;
    cmd(8'h08);
    wait_bytes(35);
    repeat (40 * BD) @(posedge clk);
    check("dma count", 8'(rx_q.size()), 8'd35);
    foreach (rx_q[i]) check("dma byte", rx_q[i], 8'h40 + 8'(i));
    check("dma blocks", 8'(n_req - r0), 8'd2);
    host_model_inst.word_mode = 1'b0;
    host_model_inst.wr(TX_COUNT_HIGH, 16'h0000);
  endtask
  // Watchdog
  initial
  begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    tally_and_finish();
  end
  // Main sequence
  initial
  begin
    repeat (5) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    t_status();
    t_frame();
    t_tic();
    t_overflow();
    t_dma();
    tally_and_finish();
  end
endmodule
